// [ccs_pkg.sv]
// ****************************************************************
// Shared constants for the CC status and output block
// ****************************************************************
package ccs_pkg;
  // CC pin classification codes from the analog comparators
  localparam logic [2:0] CLS_OPEN    = 3'h0;  // Nothing seen
  localparam logic [2:0] CLS_RA      = 3'h1;  // Below the Ra threshold
  localparam logic [2:0] CLS_RD      = 3'h2;  // Pull-down of a sink
  localparam logic [2:0] CLS_RP_DEF  = 3'h3;  // Pull-up, default current
  localparam logic [2:0] CLS_RP_MED  = 3'h4;  // Pull-up, 1.5 A
  localparam logic [2:0] CLS_RP_HIGH = 3'h5;  // Pull-up, 3.0 A

  // Port mode selection
  localparam logic [1:0] MODE_DRP = 2'h0;  // Dual role (default)
  localparam logic [1:0] MODE_SNK = 2'h1;  // Sink only
  localparam logic [1:0] MODE_SRC = 2'h2;  // Source only

  // Accessory field codes
  localparam logic [2:0] ACC_NONE     = 3'h0;  // No accessory
  localparam logic [2:0] ACC_AUDIO    = 3'h4;  // Passive audio adapter
  localparam logic [2:0] ACC_AUDIO_CT = 3'h5;  // Charge-through audio adapter
  localparam logic [2:0] ACC_DBG_SNK  = 3'h6;  // Sink-debug accessory
  localparam logic [2:0] ACC_DBG_SRC  = 3'h7;  // Source-debug accessory

  // Current mode codes
  localparam logic [1:0] CUR_NONE = 2'h0;  // Unattached
  localparam logic [1:0] CUR_DEF  = 2'h1;  // Default current
  localparam logic [1:0] CUR_MED  = 2'h2;  // 1.5 A
  localparam logic [1:0] CUR_HIGH = 2'h3;  // 3.0 A

  // Current mode pin patterns {pin_a, pin_b}, 1 = released
  localparam logic [1:0] PAT_UNATT = 2'h3;
  localparam logic [1:0] PAT_DEF   = 2'h2;
  localparam logic [1:0] PAT_MED   = 2'h1;
  localparam logic [1:0] PAT_HIGH  = 2'h0;

  // Miscellaneous reset and level values
  localparam logic       OD_LEVEL    = 1'b0;  // Open-drain pins only ever pull low
  localparam logic       OE_RELEASE  = 1'b1;  // Output enable, active low
  localparam logic       ORIENT_CC1  = 1'b0;  // Orientation: CC1 carries CC
  localparam logic       ORIENT_CC2  = 1'b1;  // Orientation: CC2 carries CC

  // Accessory tracking states, one-hot
  typedef enum logic [3:0] {
    ACC_ST_IDLE    = 4'b0001,
    ACC_ST_AUDIO   = 4'b0010,
    ACC_ST_DBG_SNK = 4'b0100,
    ACC_ST_DBG_SRC = 4'b1000
  } ccs_acc_st_t;

  // Any pull-up class
  function automatic logic ccs_is_rp(input logic [2:0] cls);
    ccs_is_rp = (cls == CLS_RP_DEF) || (cls == CLS_RP_MED) || (cls == CLS_RP_HIGH);
  endfunction : ccs_is_rp
endpackage : ccs_pkg

// [ccs_strap.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Address strap capture
// ****************************************************************
module ccs_strap (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_addr_float,
  output logic      o_gpio_mode,
  output logic      o_valid
);
  import ccs_pkg::*;

  logic gpio_r;  // Latched output mode
  logic done_r;  // Strap has been taken

  // Taken once on the first edge after release; a reset may not load a pin
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      gpio_r <= 1'b0;
      done_r <= 1'b0;
    end else if (!done_r) begin
      gpio_r <= i_addr_float;
      done_r <= 1'b1;
    end
  end

  assign o_gpio_mode = gpio_r;
  assign o_valid     = done_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  strap_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    done_r |=> ($stable(gpio_r) && done_r))
    else $error("strap mode changed after capture");
  strap_take_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !done_r |=> (done_r && gpio_r == $past(i_addr_float)))
    else $error("strap not captured from the pin");
endmodule : ccs_strap
`default_nettype wire

// [ccs_chg_det.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Status change detector
// ****************************************************************
module ccs_chg_det #(
  parameter int W = 8
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_vec,
  output logic              o_pulse
);
  import ccs_pkg::*;

  logic [W-1:0] prev_r;   // Last seen status
  logic         armed_r;  // First sample taken
  logic         pulse_r;  // One-cycle change flag

  // Track the last value; the first sample after reset raises nothing
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_r  <= '0;
      armed_r <= 1'b0;
      pulse_r <= 1'b0;
    end else begin
      prev_r  <= i_vec;
      armed_r <= 1'b1;
      pulse_r <= armed_r && (i_vec != prev_r);
    end
  end

  assign o_pulse = pulse_r;

  chg_pulse_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (armed_r && i_vec != prev_r) |=> pulse_r)
    else $error("status change missed");
endmodule : ccs_chg_det
`default_nettype wire

// [ccs_status_top.sv]
`timescale 1ns/10ps
`default_nettype none
module ccs_status_top (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_addr_float,       // Strap pin sensed floating
  input  wire logic [1:0] i_port_mode,        // Port mode selection
  input  wire logic       i_role_src,         // Dual role currently source
  input  wire logic [2:0] i_cc1_cls,          // CC1 classification
  input  wire logic [2:0] i_cc2_cls,          // CC2 classification
  input  wire logic       i_attached_src,     // Attached as source
  input  wire logic       i_attached_snk,     // Attached as sink (debounced)
  input  wire logic       i_bus_power_sense,  // VBUS present
  input  wire logic       i_int_clear,        // Host write clearing status
  input  wire logic [1:0] i_adv_cur_req,      // Requested advertisement
  output logic            o_gpio_mode,
  output logic [2:0]      o_accessory,
  output logic            o_orient,
  output logic [1:0]      o_cur_detect,
  output logic            o_int_status,
  output logic [1:0]      o_adv_cur,
  output logic            o_vconn_cc1_en,
  output logic            o_vconn_cc2_en,
  output logic            o_irq_or_audio_out_n_o,
  output logic            o_irq_or_audio_out_n_oe_n,
  output logic            o_current_mode_pin_a_o,
  output logic            o_current_mode_pin_a_oe_n,
  output logic            o_current_mode_pin_b_o,
  output logic            o_current_mode_pin_b_oe_n,
  output logic            o_dir_o,
  output logic            o_dir_oe_n
);
  import ccs_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        gpio_mode;      // From the strap catcher
  logic        strap_valid;    // Strap taken
  logic        upd_p;          // Status changed, one cycle
  logic        acting_src;     // Behaving as source now
  logic        acting_snk;     // Behaving as sink now
  logic        audio_seen;     // Both pins below Ra
  logic        dbg_snk_seen;   // Debug accessory as source
  logic        dbg_src_seen;   // Debug accessory as sink
  logic        snk_att;        // Sink attach confirmed by VBUS
  logic        src_att;        // Source attached
  logic        cc1_valid;      // CC1 carries the connection
  logic        cc2_valid;      // CC2 carries the connection
  ccs_acc_st_t acc_st_r;       // Accessory tracker
  ccs_acc_st_t acc_st_nxt;
  logic [2:0]  acc_code_r;     // Accessory field
  logic        orient_r;       // Orientation status
  logic        dir_oe_n_r;     // Direction pin enable
  logic [1:0]  cur_r;          // Detected current
  logic [1:0]  cur_nxt;
  logic [1:0]  pat_r;          // Current pins {a, b}
  logic [1:0]  adv_r;          // Advertised current
  logic        int_status_r;   // Interrupt status bit
  logic        int_status_nxt;
  logic        irq_oe_n_r;     // Shared pin enable
  logic        vconn1_r;       // VCONN onto CC1
  logic        vconn2_r;       // VCONN onto CC2
  logic        od_r;           // Level of every open-drain pin

  // ****************************************************************
  // Sub-blocks
  // ****************************************************************
  ccs_strap u_strap (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_addr_float (i_addr_float),
    .o_gpio_mode  (gpio_mode),
    .o_valid      (strap_valid)
  );

  // Any new reportable information raises an update
  ccs_chg_det #(.W(7)) u_chg (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_vec   ({acc_code_r, orient_r, cur_r, vconn1_r | vconn2_r}),
    .o_pulse (upd_p)
  );

  // ****************************************************************
  // Role and CC decoding
  // ****************************************************************
  always_comb begin
    acting_src   = (i_port_mode == MODE_SRC) || ((i_port_mode == MODE_DRP) && i_role_src);
    acting_snk   = (i_port_mode == MODE_SNK) || ((i_port_mode == MODE_DRP) && !i_role_src);
    audio_seen   = (i_cc1_cls == CLS_RA) && (i_cc2_cls == CLS_RA);
    // VBUS on a sink-debug hookup means charge-through: refused off pure source
    dbg_snk_seen = acting_src && (i_cc1_cls == CLS_RD) && (i_cc2_cls == CLS_RD)
                   && !((i_port_mode != MODE_SRC) && i_bus_power_sense);
    dbg_src_seen = acting_snk && ccs_is_rp(i_cc1_cls) && ccs_is_rp(i_cc2_cls)
                   && i_bus_power_sense;
    snk_att      = acting_snk && i_attached_snk && i_bus_power_sense;
    src_att      = acting_src && i_attached_src;
    cc1_valid    = acting_snk ? ccs_is_rp(i_cc1_cls) : (i_cc1_cls == CLS_RD);
    cc2_valid    = acting_snk ? ccs_is_rp(i_cc2_cls) : (i_cc2_cls == CLS_RD);
  end

  // ****************************************************************
  // Accessory tracking
  // ****************************************************************
  // Audio has priority; each state exits as soon as its pattern goes
  always_comb begin
    acc_st_nxt = acc_st_r;
    case (acc_st_r)
      ACC_ST_IDLE: begin
        if (audio_seen) begin
          acc_st_nxt = ACC_ST_AUDIO;
        end else if (dbg_snk_seen) begin
          acc_st_nxt = ACC_ST_DBG_SNK;
        end else if (dbg_src_seen) begin
          acc_st_nxt = ACC_ST_DBG_SRC;
        end
      end
      ACC_ST_AUDIO: begin
        if (!audio_seen) acc_st_nxt = ACC_ST_IDLE;
      end
      ACC_ST_DBG_SNK: begin
        // Straight to audio so a swap costs no extra idle cycle
        if (!dbg_snk_seen) acc_st_nxt = audio_seen ? ACC_ST_AUDIO : ACC_ST_IDLE;
      end
      ACC_ST_DBG_SRC: begin
        // Losing bus power ends source-debug
        if (!dbg_src_seen) acc_st_nxt = audio_seen ? ACC_ST_AUDIO : ACC_ST_IDLE;
      end
      default: begin
        acc_st_nxt = ACC_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) acc_st_r <= ACC_ST_IDLE;
    else       acc_st_r <= acc_st_nxt;
  end

  // Accessory field, readable in every mode
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc_code_r <= ACC_NONE;
    end else begin
      case (acc_st_r)
        ACC_ST_AUDIO:   acc_code_r <= i_bus_power_sense ? ACC_AUDIO_CT : ACC_AUDIO;
        ACC_ST_DBG_SNK: acc_code_r <= ACC_DBG_SNK;
        ACC_ST_DBG_SRC: acc_code_r <= ACC_DBG_SRC;
        default:        acc_code_r <= ACC_NONE;
      endcase
    end
  end

  // ****************************************************************
  // Orientation and direction pin
  // ****************************************************************
  // Last valid side is held so the mux does not flap on detach
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      orient_r   <= ORIENT_CC1;
      dir_oe_n_r <= OE_RELEASE;
    end else if (cc1_valid) begin
      orient_r   <= ORIENT_CC1;
      dir_oe_n_r <= 1'b0;
    end else if (cc2_valid) begin
      orient_r   <= ORIENT_CC2;
      dir_oe_n_r <= OE_RELEASE;
    end
  end

  // ****************************************************************
  // Current mode
  // ****************************************************************
  // Sink reports what the partner advertises; source shows default
  always_comb begin
    cur_nxt = CUR_NONE;
    if (snk_att) begin
      case (orient_r ? i_cc2_cls : i_cc1_cls)
        CLS_RP_MED:  cur_nxt = CUR_MED;
        CLS_RP_HIGH: cur_nxt = CUR_HIGH;
        default:     cur_nxt = CUR_DEF;
      endcase
    end else if (src_att) begin
      cur_nxt = CUR_DEF;
    end
  end

  // Detected current and the two pins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cur_r <= CUR_NONE;
      pat_r <= PAT_UNATT;
    end else begin
      cur_r <= cur_nxt;
      if (!gpio_mode) begin
        pat_r <= PAT_UNATT;  // Pins idle in register mode
      end else begin
        case (cur_nxt)
          CUR_DEF:  pat_r <= PAT_DEF;
          CUR_MED:  pat_r <= PAT_MED;
          CUR_HIGH: pat_r <= PAT_HIGH;
          default:  pat_r <= PAT_UNATT;
        endcase
      end
    end
  end

  // Advertisement: register choice is ignored without a serial bus
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst)          adv_r <= CUR_DEF;
    else if (gpio_mode) adv_r <= CUR_DEF;
    else                adv_r <= i_adv_cur_req;
  end

  // ****************************************************************
  // Interrupt status and shared pin
  // ****************************************************************
  // A change in the clearing cycle wins, so no event is lost
  always_comb begin
    int_status_nxt = int_status_r;
    if (i_int_clear) int_status_nxt = 1'b0;
    if (upd_p && !gpio_mode) int_status_nxt = 1'b1;
  end

  // Status bit and pin move together in register mode; in GPIO mode the pin shows audio
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      int_status_r <= 1'b0;
      irq_oe_n_r   <= OE_RELEASE;
    end else begin
      int_status_r <= int_status_nxt;
      if (gpio_mode) irq_oe_n_r <= (acc_st_r != ACC_ST_AUDIO);
      else           irq_oe_n_r <= !int_status_nxt;
    end
  end

  // ****************************************************************
  // VCONN switch
  // ****************************************************************
  // Ra is masked once VCONN is on, so only detach or leaving the source role turns it off
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      vconn1_r <= 1'b0;
      vconn2_r <= 1'b0;
    end else if (!i_attached_src || !acting_src) begin
      vconn1_r <= 1'b0;
      vconn2_r <= 1'b0;
    end else if (!vconn1_r && !vconn2_r && src_att) begin
      vconn2_r <= (i_cc1_cls == CLS_RD) && (i_cc2_cls == CLS_RA);
      vconn1_r <= (i_cc2_cls == CLS_RD) && (i_cc1_cls == CLS_RA);
    end
  end

  // Open-drain level: never high
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) od_r <= OD_LEVEL;
    else       od_r <= OD_LEVEL;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_gpio_mode               = gpio_mode;
  assign o_accessory               = acc_code_r;
  assign o_orient                  = orient_r;
  assign o_cur_detect              = cur_r;
  assign o_int_status              = int_status_r;
  assign o_adv_cur                 = adv_r;
  assign o_vconn_cc1_en            = vconn1_r;
  assign o_vconn_cc2_en            = vconn2_r;
  assign o_irq_or_audio_out_n_o    = od_r;
  assign o_irq_or_audio_out_n_oe_n = irq_oe_n_r;
  assign o_current_mode_pin_a_o    = od_r;
  assign o_current_mode_pin_a_oe_n = pat_r[1];
  assign o_current_mode_pin_b_o    = od_r;
  assign o_current_mode_pin_b_oe_n = pat_r[0];
  assign o_dir_o                   = od_r;
  assign o_dir_oe_n                = dir_oe_n_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  int_set_a: assert property ((upd_p && !gpio_mode) |=> int_status_r)
    else $error("update did not set interrupt status");
  int_clr_a: assert property ((i_int_clear && !upd_p) |=> !int_status_r)
    else $error("host clear ignored");
  irq_hold_a: assert property ((!gpio_mode && strap_valid) |=>
    (irq_oe_n_r == !int_status_r))
    else $error("interrupt line does not follow status");
  audio_pin_a: assert property ((gpio_mode && acc_st_r == ACC_ST_AUDIO) |=> !irq_oe_n_r)
    else $error("audio not shown on shared pin");
  audio_code_a: assert property (audio_seen ##1 audio_seen |=>
    (acc_code_r == ACC_AUDIO || acc_code_r == ACC_AUDIO_CT))
    else $error("audio adapter not reported");
  dbg_snk_a: assert property ((acc_st_r == ACC_ST_DBG_SNK) |=> acc_code_r == ACC_DBG_SNK)
    else $error("sink-debug code wrong");
  dbg_src_a: assert property ((acc_st_r == ACC_ST_DBG_SRC) |=> acc_code_r == ACC_DBG_SRC)
    else $error("source-debug code wrong");
  dbg_ct_a: assert property ((i_port_mode != MODE_SRC && i_bus_power_sense) |->
    !dbg_snk_seen)
    else $error("charge-through debug accepted");
  dir_pin_a: assert property (cc1_valid |=> (!dir_oe_n_r && orient_r == ORIENT_CC1))
    else $error("direction pin not low for CC1");
  cur_pin_a: assert property ((gpio_mode && cur_nxt == CUR_HIGH) |=> pat_r == PAT_HIGH)
    else $error("high current pattern wrong");
  adv_def_a: assert property (gpio_mode |=> adv_r == CUR_DEF)
    else $error("non-default advertisement in GPIO mode");
  vconn_on_a: assert property ($rose(vconn2_r) |->
    $past(src_att && i_cc2_cls == CLS_RA && i_cc1_cls == CLS_RD))
    else $error("VCONN enabled without cause");
  vconn_off_a: assert property (!i_attached_src |=> !(vconn1_r || vconn2_r))
    else $error("VCONN left on after detach");
  od_low_a: assert property (od_r == OD_LEVEL)
    else $error("open-drain pin driven high");

  audio_c: cover property (gpio_mode && acc_st_r == ACC_ST_AUDIO ##1 !irq_oe_n_r);
  vconn_c: cover property (!vconn2_r ##1 vconn2_r);
  irq_c:   cover property (int_status_r ##1 i_int_clear ##1 !int_status_r);
endmodule : ccs_status_top
`default_nettype wire

// [ccs_partner.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Far side: partner, cable or accessory
// ****************************************************************
module ccs_partner
  import ccs_pkg::*;
(
  input  wire logic [2:0] i_kind,   // What is plugged in
  input  wire logic [2:0] i_rp,     // Pull-up class of a source
  input  wire logic       i_flip,   // Plug turned over
  input  wire logic       i_power,  // Source switches bus power on
  output logic [2:0]      o_cc1,
  output logic [2:0]      o_cc2,
  output logic            o_vbus
);
  logic [6:0] t;  // {near pin, far pin, powered}
  // Terminations per kind; only the Rp kinds and charge-through debug power the bus
  always_comb begin
    case (i_kind)
      3'h1:    t = {CLS_RA, CLS_RA, 1'b0};    // Passive audio
      3'h2:    t = {CLS_RD, CLS_RD, 1'b0};    // Sink-side debug
      3'h3:    t = {i_rp, i_rp, 1'b1};        // Source-side debug
      3'h4:    t = {CLS_RD, CLS_RA, 1'b0};    // Sink via active cable
      3'h5:    t = {i_rp, CLS_OPEN, 1'b1};    // Plain source
      3'h6:    t = {CLS_RA, CLS_OPEN, 1'b0};  // Lone Ra, not audio
      3'h7:    t = {CLS_RD, CLS_RD, 1'b1};    // Charge-through debug
      default: t = {CLS_OPEN, CLS_OPEN, 1'b0};
    endcase
  end
  // Flip swaps the pins, so orientation is seen from both sides
  assign o_cc1  = i_flip ? t[3:1] : t[6:4];
  assign o_cc2  = i_flip ? t[6:4] : t[3:1];
  assign o_vbus = t[0] & i_power;
endmodule : ccs_partner
`default_nettype wire

// [tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
  import ccs_pkg::*;
  logic        clk, rst, afloat, rsrc, asrc, asnk, clr, flip, pwr, vbus;
  logic [1:0]  mode, areq, cur, adv;
  logic [2:0]  kind, rp, cc1, cc2, acc;
  logic        gpio, orient, ists, v1, v2, irq_o, irq_oe, pa_o, pa_oe, pb_o, pb_oe, dir_o, dir_oe;
  logic [31:0] seed;
  int          mismatches = 0;
  int          comparisons = 0;
  int          cycles = 0;
  ccs_partner i_far (.i_kind(kind), .i_rp(rp), .i_flip(flip), .i_power(pwr), .o_cc1(cc1),
                     .o_cc2(cc2), .o_vbus(vbus));
  ccs_status_top i_dut (
    .i_clk(clk), .i_rst(rst), .i_addr_float(afloat), .i_port_mode(mode), .i_role_src(rsrc),
    .i_cc1_cls(cc1), .i_cc2_cls(cc2), .i_attached_src(asrc), .i_attached_snk(asnk),
    .i_bus_power_sense(vbus), .i_int_clear(clr), .i_adv_cur_req(areq), .o_gpio_mode(gpio),
    .o_accessory(acc), .o_orient(orient), .o_cur_detect(cur), .o_int_status(ists),
    .o_adv_cur(adv), .o_vconn_cc1_en(v1), .o_vconn_cc2_en(v2),
    .o_irq_or_audio_out_n_o(irq_o), .o_irq_or_audio_out_n_oe_n(irq_oe),
    .o_current_mode_pin_a_o(pa_o), .o_current_mode_pin_a_oe_n(pa_oe),
    .o_current_mode_pin_b_o(pb_o), .o_current_mode_pin_b_oe_n(pb_oe),
    .o_dir_o(dir_o), .o_dir_oe_n(dir_oe)
  );
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // Released pins are 1, so the pattern is the inverted current code
  function automatic logic [1:0] exp_pins(input logic [2:0] cls, input logic att);
    exp_pins = att ? ~2'(cls - 3'h2) : 2'b11;
  endfunction : exp_pins
  // Reset at a falling edge; strap is sampled right after release
  task automatic do_reset(input logic f);
    @(negedge clk);
    rst = 1'b1;
    afloat = f;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (2) @(negedge clk);
  endtask : do_reset
  // Inputs change on the falling edge; five cycles cover every latency
  task automatic apply(input logic [2:0] k, input logic [1:0] m, input logic rs,
                       input logic as, input logic an);
    @(negedge clk);
    kind = k;
    mode = m;
    rsrc = rs;
    asrc = as;
    asnk = an;
    repeat (5) @(negedge clk);
  endtask : apply
  task automatic acc_case(input logic [2:0] k, input logic [1:0] m, input logic rs,
                          input logic [2:0] e);
    apply(k, m, rs, 1'b0, 1'b0);
    check(acc, e, "accessory");
  endtask : acc_case
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {afloat, mode, rsrc, asrc, asnk, clr, flip, pwr, kind} = '0;
    rst = 1'b1;
    rp = CLS_RP_DEF;
    areq = CUR_HIGH;
    seed = 32'h551fee93;
    do_reset(1'b0);
    check(gpio, 1'b0, "strap");
    check(adv, CUR_HIGH, "adv req");
    check({irq_oe, pa_oe, pb_oe, dir_oe}, 4'hf, "released");
    apply(3'h1, MODE_DRP, 1'b0, 1'b0, 1'b0);
    check(acc, ACC_AUDIO, "audio");
    check({ists, irq_oe}, 2'b10, "irq set");
    repeat (8) @(negedge clk);
    check(irq_oe, 1'b0, "irq held");
    @(negedge clk);
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    repeat (2) @(negedge clk);
    check({ists, irq_oe}, 2'b01, "irq clear");
    acc_case(3'h6, MODE_DRP, 1'b0, ACC_NONE);
    acc_case(3'h2, MODE_SRC, 1'b0, ACC_DBG_SNK);
    acc_case(3'h2, MODE_DRP, 1'b1, ACC_DBG_SNK);
    pwr = 1'b1;
    acc_case(3'h3, MODE_SNK, 1'b0, ACC_DBG_SRC);
    acc_case(3'h3, MODE_DRP, 1'b0, ACC_DBG_SRC);
    acc_case(3'h7, MODE_DRP, 1'b1, ACC_NONE);
    acc_case(3'h7, MODE_SNK, 1'b0, ACC_NONE);
    pwr = 1'b0;
    acc_case(3'h3, MODE_SNK, 1'b0, ACC_NONE);
    pwr = 1'b1;
    rp = CLS_RP_MED;
    apply(3'h5, MODE_SNK, 1'b0, 1'b0, 1'b1);
    check({orient, dir_oe, cur}, {2'b00, CUR_MED}, "cc1");
    flip = 1'b1;
    apply(3'h5, MODE_SNK, 1'b0, 1'b0, 1'b1);
    check({orient, dir_oe}, 2'b11, "cc2");
    pwr = 1'b0;
    apply(3'h5, MODE_SNK, 1'b0, 1'b0, 1'b1);
    check(cur, CUR_NONE, "no power");
    apply(3'h4, MODE_SRC, 1'b1, 1'b1, 1'b0);
    check({v1, v2}, 2'b10, "vconn cc1");
    apply(3'h4, MODE_SRC, 1'b1, 1'b0, 1'b0);
    check({v1, v2}, 2'b00, "vconn off");
    flip = 1'b0;
    apply(3'h4, MODE_SRC, 1'b1, 1'b1, 1'b0);
    check({v1, v2}, 2'b01, "vconn cc2");
    do_reset(1'b1);
    check({gpio, pa_oe, pb_oe}, {1'b1, PAT_DEF}, "gpio");
    apply(3'h1, MODE_DRP, 1'b0, 1'b0, 1'b0);
    check({ists, irq_oe}, 2'b00, "audio pin");
    apply(3'h0, MODE_DRP, 1'b0, 1'b0, 1'b0);
    check(irq_oe, 1'b1, "audio gone");
    pwr = 1'b1;
    repeat (24) begin
      seed = lfsr(seed);
      rp = CLS_RP_DEF + {1'b0, seed[1:0] % 2'h3};
      flip = seed[2];
      areq = seed[5:4];
      apply(3'h5, MODE_DRP, 1'b0, 1'b0, seed[3]);
      check({pa_oe, pb_oe}, exp_pins(rp, seed[3]), "pins");
      check(adv, CUR_DEF, "adv");
      check({orient, dir_o, pa_o, pb_o, irq_o}, {flip, 4'h0}, "levels");
    end
    give_verdict();
  end
endmodule : tb
`default_nettype wire
